// file: core/fpccd_pkg.sv
// package for the floating compare / divide / convert datapath
// assumes a single 50 MHz clock domain and a plain register port
package fpccd_pkg;
    // ==========================================================
    // operation codes
    typedef enum logic [2:0] {
        FPCCD_OP_NONE = 3'b000,
        FPCCD_OP_COPY = 3'b001,
        FPCCD_OP_CMP = 3'b010,
        FPCCD_OP_DIV = 3'b011,
        FPCCD_OP_CVT = 3'b100,
        FPCCD_OP_I2F = 3'b101
    } fpccd_op_type;
    // ==========================================================
    // register offsets (word index on the register port)
    localparam logic [3:0] REG_FPS = 4'h0;
    localparam logic [3:0] REG_FEC = 4'h1;
    localparam logic [3:0] REG_IRQ_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_MASK = 4'h3;
    localparam logic [3:0] REG_FLAGS = 4'h4;
    // status register bit positions
    localparam int FPS_IUV = 11;
    localparam int FPS_IU = 10;
    localparam int FPS_IV = 9;
    localparam int FPS_FD = 7;
    localparam int FPS_FL = 6;
    localparam int FPS_FT = 5;
    localparam logic [15:0] FPS_RST = 16'h0000;
    // exception codes
    localparam logic [3:0] FEC_DIV0 = 4'h4;
    localparam logic [3:0] FEC_NONE = 4'h0;
    // interrupt event bits
    localparam int EV_DIV0 = 0;
    localparam int EV_OVF = 1;
    localparam int EV_UNF = 2;
    localparam int EV_UVT = 3;
    localparam int EV_W = 4;
    // floating format
    localparam int EXP_W = 8;
    localparam int FRAC_D = 55;
    localparam int FRAC_F = 23;
    localparam logic [7:0] EXP_BIAS = 8'h80;
    localparam int GUARD_W = 2;
endpackage

// file: core/fpccd_round.sv
// rounding / chopping of a wide fraction to single or double width
// assumes input fraction has hidden bit at msb
`timescale 1ns/1ps
module fpccd_round
    import fpccd_pkg::*;
#(
    parameter int IN_W = 58
)(
    input wire logic [IN_W-1:0] frac_in, // fraction, hidden bit at msb
    input wire logic dbl, // double-width result
    input wire logic chop, // truncate instead of round
    output logic [FRAC_D:0] frac_out, // rounded fraction with hidden bit
    output logic carry_out // rounding overflowed the fraction
);
    logic [FRAC_D+1:0] tr;
    logic rbit;
    // pick the truncated value and the first discarded bit
    always_comb
    begin
        if (dbl)
        begin
            tr = {1'b0, frac_in[IN_W-1 -: FRAC_D+1]};
            rbit = frac_in[IN_W-FRAC_D-2];
        end
        else
        begin
            tr = {1'b0, frac_in[IN_W-1 -: FRAC_F+1], {(FRAC_D-FRAC_F){1'b0}}};
            rbit = frac_in[IN_W-FRAC_F-2];
        end
        if (!chop && rbit)
            tr = tr + (dbl ? {{FRAC_D+1{1'b0}}, 1'b1} : {{FRAC_F+1{1'b0}}, 1'b1, {(FRAC_D-FRAC_F){1'b0}}});
        carry_out = tr[FRAC_D+1];
        frac_out = carry_out ? tr[FRAC_D+1:1] : tr[FRAC_D:0];
    end
endmodule // fpccd_round

// file: core/fpccd_div.sv
// iterative restoring fraction divider
// assumes both fractions normalised with hidden bit set
`timescale 1ns/1ps
module fpccd_div
    import fpccd_pkg::*;
#(
    parameter int Q_W = 58
)(
    input wire logic core_clk, // clock
    input wire logic rstn, // async reset, active low
    input wire logic start, // one-cycle start pulse
    input wire logic [FRAC_D:0] num, // dividend fraction
    input wire logic [FRAC_D:0] den, // divisor fraction
    output logic busy, // divide running
    output logic [Q_W-1:0] quot // quotient, valid when busy falls
);
    logic [FRAC_D+1:0] rem_q;
    logic [6:0] cnt_q;
    logic [FRAC_D+1:0] diff;
    assign diff = rem_q - {1'b0, den};
    // one quotient bit per cycle, guard bits included
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rem_q <= '0;
            cnt_q <= '0;
            busy <= 1'b0;
            quot <= '0;
        end
        else if (start)
        begin
            rem_q <= {1'b0, num};
            cnt_q <= 7'(Q_W);
            busy <= 1'b1;
            quot <= '0;
        end
        else if (busy)
        begin
            if (!diff[FRAC_D+1])
            begin
                rem_q <= {diff[FRAC_D:0], 1'b0};
                quot <= {quot[Q_W-2:0], 1'b1};
            end
            else
            begin
                rem_q <= {rem_q[FRAC_D:0], 1'b0};
                quot <= {quot[Q_W-2:0], 1'b0};
            end
            cnt_q <= cnt_q - 7'h01;
            busy <= (cnt_q != 7'h01);
        end
    end
endmodule // fpccd_div

// file: core/fpccd_top.sv
// floating compare, divide and precision / integer convert datapath
// assumes the core issues one op with start and waits for done
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
// Functional notes
// - copy floating flags into cpu flags
// - compare sets zero and negative flags
// - compare leaves operands unchanged
// - zero exponent means exact zero
// - divide by zero aborts, code four
// - quotient carries two guard bits
// - chop bit selects round or truncate
// - overflow/underflow with FPS_IV / FPS_IU clear stores exact zero
// - double mode selects conversion direction
// - double to single chops or rounds
// - long mode selects 32/16 bit integers
// - round adds lsb on discarded one
module fpccd_top
    import fpccd_pkg::*;
(
    input wire logic core_clk, // 50 MHz clock
    input wire logic rstn, // async reset, active low
    input wire logic start, // one-cycle op request
    input wire logic [2:0] op, // fpccd_op_type code
    input wire logic [63:0] src_in, // source operand
    input wire logic [63:0] acc_in, // selected accumulator
    input wire logic [3:0] reg_addr, // register word index
    input wire logic [15:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [15:0] reg_rdata, // read data, cycle after strobe
    output logic done, // op finished pulse
    output logic acc_we, // accumulator write pulse
    output logic [63:0] acc_out, // accumulator write value
    output logic [3:0] cpu_flags, // n z v c for the cpu
    output logic cpu_flags_we, // cpu flag load pulse
    output logic trap, // undefined variable trap pulse
    output logic irq // level interrupt
);
    // ==========================================================
    // state
    typedef enum logic [1:0] {
        FPCCD_IDLE = 2'b00,
        FPCCD_DIVW = 2'b01,
        FPCCD_DFIN = 2'b10
    } fpccd_st_type;
    fpccd_st_type st_q;
    logic [15:0] fps_q;
    logic [3:0] fec_q;
    logic [EV_W-1:0] ist_q, imask_q;
    logic [3:0] fcc_q; // n z v c
    logic [63:0] acc_q;
    logic [EV_W-1:0] ev;
    logic dbl, chop, lng, iuv;
    assign dbl = fps_q[FPS_FD];
    assign chop = fps_q[FPS_FT];
    assign lng = fps_q[FPS_FL];
    assign iuv = fps_q[FPS_IUV];

    // field helpers
    function automatic logic [7:0] fexp(input logic [63:0] v);
        fexp = v[62:55];
    endfunction
    function automatic logic is_negz(input logic [63:0] v);
        is_negz = v[63] && (fexp(v) == 8'h00);
    endfunction
    function automatic logic [FRAC_D:0] fmant(input logic [63:0] v);
        fmant = {1'b1, v[54:0]};
    endfunction

    // ==========================================================
    // divide path
    logic div_go, div_busy;
    logic [57:0] quot;
    logic [FRAC_D:0] rfrac;
    logic rcarry;
    logic [9:0] qexp;
    fpccd_div #(.Q_W(FRAC_D + 1 + GUARD_W)) u_div (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(div_go),
        .num(fmant(acc_in)),
        .den(fmant(src_in)),
        .busy(div_busy),
        .quot(quot)
    );
    logic [57:0] qn;
    logic qsh;
    // normalise: quotient of two [1,2) fractions lies in (1/2,2)
    assign qsh = !quot[57];
    assign qn = qsh ? {quot[56:0], 1'b0} : quot;

    // ==========================================================
    // conversion path shares the rounder
    logic [57:0] rnd_in;
    logic rnd_dbl;
    logic [63:0] ival;
    logic [31:0] imag;
    logic [5:0] lz;
    logic [57:0] inorm;
    always_comb
    begin
        ival = lng ? {{32{src_in[63]}}, src_in[63:32]} : {{48{src_in[63]}}, src_in[63:48]};
        imag = ival[63] ? 32'(-ival) : ival[31:0];
        lz = 6'h00;
        for (int i = 0; i < 32; i++)
            if (imag[i])
                lz = 6'(31 - i);
        inorm = {imag << lz, 26'h0000000};
    end
    always_comb
    begin
        if (st_q == FPCCD_DFIN)
        begin
            rnd_in = qn;
            rnd_dbl = dbl;
        end
        else if (op == FPCCD_OP_I2F)
        begin
            rnd_in = inorm;
            rnd_dbl = dbl;
        end
        else
        begin
            // double mode 0 converts double to single
            rnd_in = {fmant(src_in), 2'b00};
            rnd_dbl = 1'b0;
        end
    end
    fpccd_round #(.IN_W(58)) u_rnd (
        .frac_in(rnd_in),
        .dbl(rnd_dbl),
        .chop(chop),
        .frac_out(rfrac),
        .carry_out(rcarry)
    );
    // pack a result, dropping the hidden bit
    function automatic logic [63:0] fpack(input logic s, input logic [7:0] e, input logic [FRAC_D:0] f);
        fpack = {s, e, f[FRAC_D-1:0]};
    endfunction
    // ==========================================================
    // sequencing
    assign div_go = start && op == FPCCD_OP_DIV && st_q == FPCCD_IDLE && !(iuv && is_negz(src_in))
                    && fexp(src_in) != 8'h00 && fexp(acc_in) != 8'h00;
    // biased quotient exponent, ten bits to see over and underflow
    // a mantissa ratio at or above one lands one binade above the plain bias
    assign qexp = 10'(fexp(acc_in)) - 10'(fexp(src_in)) + 10'(EXP_BIAS) + 10'(rcarry) + 10'(!qsh);
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= FPCCD_IDLE;
            done <= 1'b0;
            acc_we <= 1'b0;
            acc_q <= '0;
            fcc_q <= 4'h0;
            cpu_flags_we <= 1'b0;
            trap <= 1'b0;
            ev <= '0;
            fec_q <= FEC_NONE;
        end
        else
        begin
            done <= 1'b0;
            acc_we <= 1'b0;
            cpu_flags_we <= 1'b0;
            trap <= 1'b0;
            ev <= '0;
            unique case (st_q)
                FPCCD_IDLE:
                if (start)
                begin
                    if (iuv && is_negz(src_in) && (op == FPCCD_OP_CMP || op == FPCCD_OP_DIV || op == FPCCD_OP_CVT))
                    begin
                        trap <= 1'b1;
                        done <= 1'b1;
                        ev[EV_UVT] <= 1'b1;
                    end
                    else if (op == FPCCD_OP_COPY)
                    begin
                        cpu_flags_we <= 1'b1;
                        done <= 1'b1;
                    end
                    else if (op == FPCCD_OP_CMP)
                    begin
                        fcc_q <= {src_in[63] && fexp(src_in) != 8'h00, fexp(src_in) == 8'h00, 2'b00};
                        done <= 1'b1;
                    end
                    else if (op == FPCCD_OP_DIV)
                    begin
                        if (fexp(src_in) == 8'h00)
                        begin
                            fec_q <= FEC_DIV0;
                            ev[EV_DIV0] <= 1'b1;
                            done <= 1'b1;
                        end
                        else if (fexp(acc_in) == 8'h00)
                        begin
                            acc_q <= '0;
                            acc_we <= 1'b1;
                            fcc_q <= 4'b0100;
                            done <= 1'b1;
                        end
                        else
                            st_q <= FPCCD_DIVW;
                    end
                    else if (op == FPCCD_OP_CVT || op == FPCCD_OP_I2F)
                    begin
                        acc_we <= 1'b1;
                        done <= 1'b1;
                        if (op == FPCCD_OP_I2F)
                        begin
                            acc_q <= (imag == 32'h0) ? 64'h0 :
                                fpack(ival[63], 8'(EXP_BIAS + 8'd32 - {2'b00, lz} + 8'(rcarry)), rfrac);
                            fcc_q <= {ival[63], imag == 32'h0, 2'b00};
                        end
                        else if (fexp(src_in) == 8'h00)
                        begin
                            acc_q <= '0;
                            fcc_q <= 4'b0100;
                        end
                        else if (!dbl)
                        begin
                            acc_q <= fpack(src_in[63], 8'(fexp(src_in) + 8'(rcarry)), rfrac) & {32'hFFFFFFFF, 32'h0};
                            fcc_q <= {src_in[63], 3'b000};
                        end
                        else
                        begin
                            // single to double: low half cleared
                            acc_q <= {src_in[63:32], 32'h0};
                            fcc_q <= {src_in[63], 3'b000};
                        end
                    end
                end
                FPCCD_DIVW:
                if (!div_busy && !div_go)
                    st_q <= FPCCD_DFIN;
                FPCCD_DFIN:
                begin
                    st_q <= FPCCD_IDLE;
                    done <= 1'b1;
                    if (qexp[9] || qexp[7:0] == 8'h00 && !qexp[8])
                    begin
                        ev[EV_UNF] <= 1'b1;
                        acc_we <= 1'b1;
                        acc_q <= fps_q[FPS_IU] ? fpack(src_in[63] ^ acc_in[63], qexp[7:0], rfrac) : 64'h0;
                        fcc_q <= fps_q[FPS_IU] ? {src_in[63] ^ acc_in[63], 3'b000} : 4'b0100;
                    end
                    else if (qexp[8])
                    begin
                        ev[EV_OVF] <= 1'b1;
                        acc_we <= 1'b1;
                        acc_q <= fps_q[FPS_IV] ? fpack(src_in[63] ^ acc_in[63], qexp[7:0], rfrac) : 64'h0;
                        fcc_q <= fps_q[FPS_IV] ? {src_in[63] ^ acc_in[63], 3'b010} : 4'b0110;
                    end
                    else
                    begin
                        acc_we <= 1'b1;
                        acc_q <= fpack(src_in[63] ^ acc_in[63], qexp[7:0], rfrac);
                        fcc_q <= {src_in[63] ^ acc_in[63], 3'b000};
                    end
                end
                default:
                    st_q <= FPCCD_IDLE;
            endcase
        end
    end
    assign acc_out = acc_q;
    assign cpu_flags = fcc_q;
    // ==========================================================
    // registers and interrupt; the event set beats the read clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fps_q <= FPS_RST;
            imask_q <= '0;
            ist_q <= '0;
            reg_rdata <= 16'h0000;
            irq <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == REG_FPS)
                fps_q <= reg_wdata;
            if (reg_wr && reg_addr == REG_IRQ_MASK)
                imask_q <= reg_wdata[EV_W-1:0];
            ist_q <= ((reg_rd && reg_addr == REG_IRQ_STAT) ? '0 : ist_q) | ev;
            irq <= |((((reg_rd && reg_addr == REG_IRQ_STAT) ? '0 : ist_q) | ev) & imask_q);
            reg_rdata <= 16'h0000;
            if (reg_rd)
                unique case (reg_addr)
                    REG_FPS: reg_rdata <= fps_q;
                    REG_FEC: reg_rdata <= {12'h000, fec_q};
                    REG_IRQ_STAT: reg_rdata <= {12'h000, ist_q};
                    REG_IRQ_MASK: reg_rdata <= {12'h000, imask_q};
                    REG_FLAGS: reg_rdata <= {12'h000, fcc_q};
                    default: reg_rdata <= 16'h0000;
                endcase
        end
    end
    // ==========================================================
    // checks
    a_div0_code: assert property (@(posedge core_clk) disable iff (!rstn)
        start && op == FPCCD_OP_DIV && st_q == FPCCD_IDLE && fexp(src_in) == 8'h00 && !(iuv && src_in[63])
        |=> fec_q == FEC_DIV0 && !acc_we && done)
        else $error("divide by zero not aborted");
    a_cmp_noacc: assert property (@(posedge core_clk) disable iff (!rstn)
        start && op == FPCCD_OP_CMP && st_q == FPCCD_IDLE |=> !acc_we && (trap || fcc_q[1:0] == 2'b00))
        else $error("compare wrote accumulator");
    a_negz_trap: assert property (@(posedge core_clk) disable iff (!rstn)
        start && st_q == FPCCD_IDLE && iuv && is_negz(src_in)
        && (op == FPCCD_OP_CMP || op == FPCCD_OP_DIV || op == FPCCD_OP_CVT) |=> trap && !acc_we)
        else $error("negative zero trap missing");
    a_cmp_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        start && st_q == FPCCD_IDLE && op == FPCCD_OP_CMP && !(iuv && is_negz(src_in))
        && fexp(src_in) == 8'h00 |=> fcc_q[2] && !fcc_q[3])
        else $error("compare zero flag wrong");
    a_div_zero_acc: assert property (@(posedge core_clk) disable iff (!rstn)
        start && st_q == FPCCD_IDLE && op == FPCCD_OP_DIV && fexp(src_in) != 8'h00
        && fexp(acc_in) == 8'h00 |=> acc_we && acc_q == 64'h0 && done)
        else $error("zero dividend not exact zero");
    a_copy_flags: assert property (@(posedge core_clk) disable iff (!rstn)
        start && st_q == FPCCD_IDLE && op == FPCCD_OP_COPY && !(iuv && is_negz(src_in)) |=> cpu_flags_we)
        else $error("flag copy missing");
endmodule // fpccd_top

// file: testbench/fpccd_core_model.sv
// processor core model: issues one floating op at a time and collects the answer
// assumes the datapath raises done within 300 cycles of a taken start
`timescale 1ns/1ps
module fpccd_core_model
    import fpccd_pkg::*;
(
    core_clk, // clock
    start, // op request pulse
    op, // op code
    src_in, // source operand
    acc_in, // accumulator operand
    done, // op finished pulse
    acc_we, // accumulator write pulse
    acc_out, // accumulator write value
    cpu_flags_we, // cpu flag load pulse
    trap // negative zero trap pulse
);
    input wire logic core_clk;
    output logic start;
    output logic [2:0] op;
    output logic [63:0] src_in;
    output logic [63:0] acc_in;
    input wire logic done;
    input wire logic acc_we;
    input wire logic [63:0] acc_out;
    input wire logic cpu_flags_we;
    input wire logic trap;
    // ==========================================================
    // what the last op handed back
    logic got_we;
    logic got_flags;
    logic got_trap;
    logic got_done;
    logic [63:0] got_acc;

    // idle core drives no request at time zero
    initial
    begin
        start = 1'b0;
        op = 3'h0;
        src_in = 64'h0000_0000_0000_0000;
        acc_in = 64'h0000_0000_0000_0000;
    end

    // operands stay put until done, since the divider reads them late
    task automatic issue(input logic [2:0] o, input logic [63:0] s, input logic [63:0] a);
        int i;
        got_we = 1'b0;
        got_flags = 1'b0;
        got_trap = 1'b0;
        got_done = 1'b0;
        got_acc = 64'h0000_0000_0000_0000;
        @(posedge core_clk);
        start <= 1'b1;
        op <= o;
        src_in <= s;
        acc_in <= a;
        @(posedge core_clk);
        start <= 1'b0;
        for (i = 0; i < 300; i++)
        begin
            #1;
            if (acc_we === 1'b1)
            begin
                got_we = 1'b1;
                got_acc = acc_out;
            end
            if (cpu_flags_we === 1'b1)
                got_flags = 1'b1;
            if (trap === 1'b1)
                got_trap = 1'b1;
            if (done === 1'b1)
            begin
                got_done = 1'b1;
                break;
            end
            @(posedge core_clk);
        end
    endtask
endmodule // fpccd_core_model

// file: testbench/tb_top.sv
// self-checking bench for the floating compare / divide / convert datapath
// assumes the core model in fpccd_core_model issues every op
`timescale 1ns/1ps
module tb_top;
    import fpccd_pkg::*;
    // ==========================================================
    // signals and operands
    localparam logic [63:0] ONE = 64'h4080_0000_0000_0000; // 1.0
    localparam logic [63:0] X0 = 64'h0000_0000_0000_0F0F; // zero exponent, junk fraction
    logic core_clk = 1'b0;
    logic rstn, start, reg_wr, reg_rd, done, acc_we, cpu_flags_we, trap, irq;
    logic [2:0] op;
    logic [63:0] src_in, acc_in, acc_out;
    logic [3:0] reg_addr, cpu_flags;
    logic [15:0] reg_wdata, reg_rdata;
    int err_total = 0;
    int n_checks = 0;

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    fpccd_top u_dut (.core_clk(core_clk), .rstn(rstn), .start(start), .op(op), .src_in(src_in),
        .acc_in(acc_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .done(done), .acc_we(acc_we), .acc_out(acc_out), .cpu_flags(cpu_flags),
        .cpu_flags_we(cpu_flags_we), .trap(trap), .irq(irq));
    fpccd_core_model u_core (.core_clk(core_clk), .start(start), .op(op), .src_in(src_in), .acc_in(acc_in),
        .done(done), .acc_we(acc_we), .acc_out(acc_out), .cpu_flags_we(cpu_flags_we), .trap(trap));

    // ==========================================================
    // shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(reg_rdata, e);
    endtask

    // status word from double, chop, long and trap enable bits
    task automatic mode(input logic d, input logic c, input logic l, input logic t);
        wr(REG_FPS, (16'(d) << FPS_FD) | (16'(c) << FPS_FT) | (16'(l) << FPS_FL) | (16'(t) << FPS_IUV));
    endtask

    task automatic run(input fpccd_op_type o, input logic [63:0] s, input logic [63:0] a);
        u_core.issue(o, s, a);
        // an op that never finishes counts against the run
        if (u_core.got_done !== 1'b1)
            err_total++;
    endtask

    // ==========================================================
    // watchdog: the whole sequence needs well under a thousand cycles
    initial
    begin
        #400000;
        err_total++;
        end_sim();
    end

    // main sequence
    initial
    begin
        rstn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        rd(REG_FPS, FPS_RST);
        rd(REG_FEC, {12'h000, FEC_NONE});
        rd(4'hF, 16'h0000);
        wr(REG_FPS, 16'h0EE0);
        rd(REG_FPS, 16'h0EE0);
        mode(1'b0, 1'b0, 1'b0, 1'b0);
        // compare sets flags only and never writes the accumulator
        run(FPCCD_OP_CMP, ONE, X0);
        check(cpu_flags, 4'b0000);
        check(u_core.got_we, 1'b0);
        run(FPCCD_OP_CMP, X0, ONE);
        check(cpu_flags, 4'b0100);
        run(FPCCD_OP_CMP, 64'hC080_0000_0000_0000, ONE);
        check(cpu_flags, 4'b1000);
        check(u_core.got_we, 1'b0);
        run(FPCCD_OP_COPY, X0, X0);
        check(u_core.got_flags, 1'b1);
        check(cpu_flags, 4'b1000);
        // one third in both precisions, single rounded then chopped, double chopped then rounded
        run(FPCCD_OP_DIV, 64'h4140_0000_0000_0000, ONE);
        check(u_core.got_acc[63:32], 32'h3FAA_AAAB);
        mode(1'b0, 1'b1, 1'b0, 1'b0);
        run(FPCCD_OP_DIV, 64'h4140_0000_0000_0000, ONE);
        check(u_core.got_acc[63:32], 32'h3FAA_AAAA);
        mode(1'b1, 1'b1, 1'b0, 1'b0);
        run(FPCCD_OP_DIV, 64'h4140_0000_0000_0000, ONE);
        check(u_core.got_acc, 64'h3FAA_AAAA_AAAA_AAAA);
        mode(1'b1, 1'b0, 1'b0, 1'b0);
        run(FPCCD_OP_DIV, 64'h4140_0000_0000_0000, ONE);
        check(u_core.got_acc, 64'h3FAA_AAAA_AAAA_AAAB);
        run(FPCCD_OP_DIV, ONE, 64'h4100_0000_0000_0000);
        check(u_core.got_acc, 64'h4100_0000_0000_0000);
        run(FPCCD_OP_DIV, ONE, 64'h007F_FFFF_FFFF_FFFF);
        check(u_core.got_we, 1'b1);
        check(u_core.got_acc, 64'h0000_0000_0000_0000);
        // overflow with its interrupt disabled stores exact zero
        run(FPCCD_OP_DIV, 64'h0080_0000_0000_0000, 64'h7F80_0000_0000_0000);
        check(u_core.got_acc, 64'h0000_0000_0000_0000);
        check(cpu_flags, 4'b0110);
        rd(REG_IRQ_STAT, 16'h0001 << EV_OVF);
        // divide by zero: masked first, then unmasked
        // a set mask bit lets its status bit reach the interrupt line
        wr(REG_IRQ_MASK, 16'h0000);
        run(FPCCD_OP_DIV, X0, ONE);
        check(u_core.got_we, 1'b0);
        repeat (2) @(posedge core_clk);
        #1 check(irq, 1'b0);
        rd(REG_FEC, {12'h000, FEC_DIV0});
        rd(REG_IRQ_STAT, 16'h0001 << EV_DIV0);
        wr(REG_IRQ_MASK, 16'h000F);
        run(FPCCD_OP_DIV, 64'h0000_0000_0000_0000, ONE);
        repeat (2) @(posedge core_clk);
        #1 check(irq, 1'b1);
        rd(REG_IRQ_STAT, 16'h0001 << EV_DIV0);
        rd(REG_IRQ_STAT, 16'h0000);
        #1 check(irq, 1'b0);
        // precision conversion both ways
        mode(1'b0, 1'b0, 1'b0, 1'b0);
        run(FPCCD_OP_CVT, 64'h3FAA_AAAA_AAAA_AAAA, X0);
        check(u_core.got_acc[63:32], 32'h3FAA_AAAB);
        mode(1'b0, 1'b1, 1'b0, 1'b0);
        run(FPCCD_OP_CVT, 64'h3FAA_AAAA_AAAA_AAAA, X0);
        check(u_core.got_acc[63:32], 32'h3FAA_AAAA);
        mode(1'b1, 1'b0, 1'b0, 1'b0);
        run(FPCCD_OP_CVT, 64'h3FAA_AAAB_FFFF_FFFF, X0);
        check(u_core.got_acc, 64'h3FAA_AAAB_0000_0000);
        // integer source, short then long
        mode(1'b0, 1'b0, 1'b0, 1'b0);
        run(FPCCD_OP_I2F, 64'hFFFD_1234_5678_9ABC, X0);
        check(u_core.got_acc[63:32], 32'hC140_0000);
        mode(1'b1, 1'b0, 1'b1, 1'b0);
        run(FPCCD_OP_I2F, 64'h0001_0000_FFFF_FFFF, X0);
        check(u_core.got_acc, 64'h4880_0000_0000_0000);
        // negative zero traps only when enabled
        run(FPCCD_OP_CMP, 64'h8000_0000_0000_0000, ONE);
        check(u_core.got_trap, 1'b0);
        mode(1'b1, 1'b0, 1'b0, 1'b1);
        run(FPCCD_OP_CMP, 64'h8000_0000_0000_0000, ONE);
        check(u_core.got_trap, 1'b1);
        run(FPCCD_OP_DIV, 64'h8000_0000_0000_0000, ONE);
        check(u_core.got_trap, 1'b1);
        end_sim();
    end
endmodule // tb_top
